// ==== logic/scr_pkg.sv ====
// Shared constants and types of the upper configuration register bank.
// Assumes a single AHB-Lite slave with 32-bit data and word accesses.
package scr_pkg;
  // Byte offsets
  localparam logic [11:0] OFS_SELF_REFRESH = 12'h0048;
  localparam logic [11:0] OFS_PRIO_BASE = 12'h0100;
  localparam logic [11:0] OFS_CHIP_BASE = 12'h0200;
  localparam logic [11:0] OFS_USER_IN = 12'h0300;
  localparam logic [11:0] OFS_USER_OUT = 12'h0304;
  localparam logic [11:0] OFS_IDENT_BASE = 12'h0FE0;
  localparam logic [11:0] OFS_CTRL_STATE = 12'h0010;
  localparam logic [11:0] OFS_CHIP_PROBE = 12'h0014;
  localparam logic [11:0] OFS_CHIP_HIT = 12'h0018;
  localparam int PRIO_STRIDE_SH = 4;
  localparam int CHIP_STRIDE_SH = 6;
  localparam int NUM_PRIO = 4;
  localparam int NUM_CHIP = 4;
  // Field widths
  localparam int SRT_W = 8;
  localparam int PRIO_W = 10;
  localparam int CHIP_W = 17;
  localparam int USER_W = 8;
  localparam int CHIP_ORDER_BIT = 16;
  // Identification fields (values arbitrary)
  localparam logic [11:0] ID_PART = 12'h0A5C;
  localparam logic [7:0] ID_DESIGNER = 8'h5B;
  localparam logic [3:0] ID_REVISION = 4'h2;
  localparam logic [7:0] ID_INTEG = 8'h00;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  // Controller states
  typedef enum logic [3:0] {
    SCR_ST_CONFIG = 4'b0001,
    SCR_ST_READY = 4'b0010,
    SCR_ST_PAUSED = 4'b0100,
    SCR_ST_LOWPWR = 4'b1000
  } scr_state_e;
  typedef struct packed {
    logic [7:0] max_prio;
    logic min_prio;
    logic enable;
  } scr_prio_s;
  typedef struct packed {
    logic bank_first;
    logic [7:0] match;
    logic [7:0] mask;
  } scr_chip_s;
  typedef struct packed {
    logic [1:0] htrans;
    logic [31:0] haddr;
    logic hwrite;
    logic [2:0] hsize;
    logic hsel;
    logic hready;
  } scr_ahb_req_s;
endpackage

// ==== logic/scr_regs.sv ====
// Upper configuration register bank: timing, priority, chip decode, user I/O, ident.
// Assumes hclk at 200 MHz, single word transfers, one slave on the bus.
// ----------------------------------------------------------------
// Summary of operation
// ----------------------------------------------------------------
// Summary of operation
// - Self-refresh time in low eight bits
// - Config registers accessible only in config/low-power
// - Four priority registers from 0x100
// - Priority: enable, min bit, max field
// - One chip decode register per device
// - Bit 16 selects bank or row first
// - Select when masked address byte matches
// - Mask one includes, zero excludes bit
// - User input readable in every state
// - User output writable in every state
// - Four byte ident registers form word
// - Ident fields: part, designer, revision, options
// - Ident0 returns low part code byte
// - Ident1: part upper nibble, designer low
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ps
module scr_regs #(
  parameter int NUM_CHIPS = scr_pkg::NUM_CHIP
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [7:0] user_in,
  output logic [7:0] user_out,
  output logic [3:0] ctrl_state,
  output logic [scr_pkg::NUM_PRIO*scr_pkg::PRIO_W-1:0] prio_cfg,
  output logic [scr_pkg::SRT_W-1:0] self_refresh_time,
  output logic [NUM_CHIPS-1:0] chip_hit,
  output logic chip_bank_first
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr_pend;
    logic [11:0] wr_addr;
    logic [31:0] rdata;
    logic [7:0] srt;
    logic [scr_pkg::NUM_PRIO*scr_pkg::PRIO_W-1:0] prio;
    logic [NUM_CHIPS*scr_pkg::CHIP_W-1:0] chip;
    logic [7:0] uout;
    scr_pkg::scr_state_e st;
    logic [7:0] probe;
    logic [NUM_CHIPS-1:0] hit;
    logic hit_bf;
  } scr_st_s;
  scr_st_s s_reg;
  scr_st_s s_next;
  logic acc_ok;
  logic [11:0] a;
  logic [NUM_CHIPS-1:0] hit_c;
  logic hit_bf_c;
  logic [31:0] ident;
  logic [31:0] rd_c;
  localparam int CHIP_ORDER_POS = 8;
  assign ident = {scr_pkg::ID_INTEG, scr_pkg::ID_REVISION, scr_pkg::ID_DESIGNER,
    scr_pkg::ID_PART};
  assign a = haddr[11:0];
  assign acc_ok = (s_reg.st == scr_pkg::SCR_ST_CONFIG) ||
    (s_reg.st == scr_pkg::SCR_ST_LOWPWR);
  // ----------------------------------------------------------------
  // Chip select decode
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_CHIPS; g++) begin : g_chip
      scr_pkg::scr_chip_s c;
      assign c = s_reg.chip[g*scr_pkg::CHIP_W +: scr_pkg::CHIP_W];
      assign hit_c[g] = ((s_reg.probe ^ c.match) & c.mask) == 8'h00;
    end
  endgenerate
  always_comb begin
    scr_pkg::scr_chip_s c0;
    c0 = '0;
    hit_bf_c = 1'b0;
    for (int i = NUM_CHIPS - 1; i >= 0; i--) begin
      c0 = s_reg.chip[i*scr_pkg::CHIP_W +: scr_pkg::CHIP_W];
      if (hit_c[i]) begin
        hit_bf_c = c0.bank_first;
      end
    end
  end
  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_c = scr_pkg::RST_ZERO;
    if (a == scr_pkg::OFS_USER_IN) begin
      rd_c[7:0] = user_in;
    end else if (a == scr_pkg::OFS_CTRL_STATE) begin
      rd_c[3:0] = s_reg.st;
    end else if (a == scr_pkg::OFS_CHIP_PROBE) begin
      rd_c[7:0] = s_reg.probe;
    end else if (a == scr_pkg::OFS_CHIP_HIT) begin
      rd_c[NUM_CHIPS-1:0] = s_reg.hit;
      rd_c[CHIP_ORDER_POS] = s_reg.hit_bf;
    end else if (a[11:4] == scr_pkg::OFS_IDENT_BASE[11:4] && a[1:0] == 2'b00) begin
      rd_c[7:0] = ident[{a[3:2], 3'b000} +: 8];
    end else if (acc_ok) begin
      if (a == scr_pkg::OFS_SELF_REFRESH) begin
        rd_c[7:0] = s_reg.srt;
      end
      for (int i = 0; i < scr_pkg::NUM_PRIO; i++) begin
        if (a == scr_pkg::OFS_PRIO_BASE + 12'(i << scr_pkg::PRIO_STRIDE_SH)) begin
          rd_c[scr_pkg::PRIO_W-1:0] = s_reg.prio[i*scr_pkg::PRIO_W +: scr_pkg::PRIO_W];
        end
      end
      for (int i = 0; i < NUM_CHIPS; i++) begin
        if (a == scr_pkg::OFS_CHIP_BASE + 12'(i << scr_pkg::CHIP_STRIDE_SH)) begin
          rd_c[scr_pkg::CHIP_W-1:0] = s_reg.chip[i*scr_pkg::CHIP_W +: scr_pkg::CHIP_W];
        end
      end
    end
  end
  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [11:0] wa;
    wa = s_reg.wr_addr;
    s_next = s_reg;
    s_next.hit = hit_c;
    s_next.hit_bf = hit_bf_c;
    s_next.wr_pend = 1'b0;
    if (hsel && hready && htrans[1]) begin
      s_next.wr_pend = hwrite;
      s_next.wr_addr = a;
      if (!hwrite) begin
        s_next.rdata = rd_c;
      end
    end
    if (s_reg.wr_pend) begin
      if (wa == scr_pkg::OFS_USER_OUT) begin
        s_next.uout = hwdata[7:0];
      end else if (wa == scr_pkg::OFS_CTRL_STATE) begin
        case (hwdata[3:0])
          4'b0001: s_next.st = scr_pkg::SCR_ST_CONFIG;
          4'b0010: s_next.st = scr_pkg::SCR_ST_READY;
          4'b0100: s_next.st = scr_pkg::SCR_ST_PAUSED;
          4'b1000: s_next.st = scr_pkg::SCR_ST_LOWPWR;
          default: s_next.st = s_reg.st;
        endcase
      end else if (wa == scr_pkg::OFS_CHIP_PROBE) begin
        s_next.probe = hwdata[7:0];
      end else if (acc_ok) begin
        if (wa == scr_pkg::OFS_SELF_REFRESH) begin
          s_next.srt = hwdata[7:0];
        end
        for (int i = 0; i < scr_pkg::NUM_PRIO; i++) begin
          if (wa == scr_pkg::OFS_PRIO_BASE + 12'(i << scr_pkg::PRIO_STRIDE_SH)) begin
            s_next.prio[i*scr_pkg::PRIO_W +: scr_pkg::PRIO_W] =
              hwdata[scr_pkg::PRIO_W-1:0];
          end
        end
        for (int i = 0; i < NUM_CHIPS; i++) begin
          if (wa == scr_pkg::OFS_CHIP_BASE + 12'(i << scr_pkg::CHIP_STRIDE_SH)) begin
            s_next.chip[i*scr_pkg::CHIP_W +: scr_pkg::CHIP_W] =
              hwdata[scr_pkg::CHIP_W-1:0];
          end
        end
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
      s_reg.st <= scr_pkg::SCR_ST_CONFIG;
    end else begin
      s_reg <= s_next;
    end
  end
  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hrdata = s_reg.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign user_out = s_reg.uout;
  assign ctrl_state = s_reg.st;
  assign prio_cfg = s_reg.prio;
  assign self_refresh_time = s_reg.srt;
  assign chip_hit = s_reg.hit;
  assign chip_bank_first = s_reg.hit_bf;
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic wr_srt;
  assign wr_srt = s_reg.wr_pend && s_reg.wr_addr == scr_pkg::OFS_SELF_REFRESH;
  a_srt_write_taken: assert property (wr_srt && acc_ok |=> self_refresh_time == $past(hwdata[7:0]))
    else $error("self refresh write lost");
  a_srt_locked: assert property (wr_srt && !acc_ok |=> $stable(self_refresh_time))
    else $error("self refresh changed outside config");
  a_prio_locked: assert property (!acc_ok |=> $stable(prio_cfg) || $past(acc_ok))
    else $error("priority changed outside config");
  a_uout_any_state: assert property (s_reg.wr_pend && s_reg.wr_addr == scr_pkg::OFS_USER_OUT
    |=> user_out == $past(hwdata[7:0]))
    else $error("user output not written");
  a_uin_read: assert property (hsel && hready && htrans[1] && !hwrite &&
    a == scr_pkg::OFS_USER_IN |=> hrdata[7:0] == $past(user_in) && hrdata[31:8] == 24'h0)
    else $error("user input read wrong");
  a_ident0_read: assert property (hsel && hready && htrans[1] && !hwrite &&
    a == scr_pkg::OFS_IDENT_BASE |=> hrdata == {24'h0, scr_pkg::ID_PART[7:0]})
    else $error("ident0 wrong");
  a_ident1_read: assert property (hsel && hready && htrans[1] && !hwrite &&
    a == scr_pkg::OFS_IDENT_BASE + 12'h004 |=>
    hrdata == {24'h0, scr_pkg::ID_DESIGNER[3:0], scr_pkg::ID_PART[11:8]})
    else $error("ident1 wrong");
  a_chip_hit_full: assert property (##1 (s_reg.chip[7:0] == 8'hFF &&
    $stable(s_reg.chip) && $stable(s_reg.probe)) |->
    chip_hit[0] == (s_reg.probe == s_reg.chip[15:8]))
    else $error("chip match wrong");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not okay");

  // ----------------------------------------------------------------
  // Access gating and controller state
  // ----------------------------------------------------------------
  logic rd_req;
  assign rd_req = hsel && hready && htrans[1] && !hwrite;

  a_srt_read_open: assert property (rd_req && a == scr_pkg::OFS_SELF_REFRESH && acc_ok
    |=> hrdata == {24'h0, $past(s_reg.srt)})
    else $error("self refresh read wrong");

  a_srt_read_shut: assert property (rd_req && a == scr_pkg::OFS_SELF_REFRESH && !acc_ok
    |=> hrdata == 32'h0000_0000)
    else $error("self refresh read outside config");

  a_prio_read_shut: assert property (rd_req && a == scr_pkg::OFS_PRIO_BASE && !acc_ok
    |=> hrdata == 32'h0000_0000)
    else $error("priority read outside config");

  a_chip_read_shut: assert property (rd_req && a == scr_pkg::OFS_CHIP_BASE && !acc_ok
    |=> hrdata == 32'h0000_0000)
    else $error("chip read outside config");

  a_srt_all_locked: assert property (!acc_ok |=> $stable(self_refresh_time))
    else $error("self refresh moved while locked");

  a_chip_locked: assert property (!acc_ok |=> $stable(s_reg.chip))
    else $error("chip config moved while locked");

  a_state_onehot: assert property ($onehot(ctrl_state))
    else $error("controller state not one-hot");

  a_state_hold: assert property (!(s_reg.wr_pend && s_reg.wr_addr == scr_pkg::OFS_CTRL_STATE)
    |=> $stable(ctrl_state))
    else $error("controller state moved");

  // ----------------------------------------------------------------
  // Stored values
  // ----------------------------------------------------------------
  a_prio0_write: assert property (s_reg.wr_pend && s_reg.wr_addr == scr_pkg::OFS_PRIO_BASE &&
    acc_ok |=> prio_cfg[scr_pkg::PRIO_W-1:0] == $past(hwdata[scr_pkg::PRIO_W-1:0]))
    else $error("priority 0 write lost");

  a_prio3_write: assert property (s_reg.wr_pend &&
    s_reg.wr_addr == scr_pkg::OFS_PRIO_BASE + 12'h030 && acc_ok
    |=> prio_cfg[3*scr_pkg::PRIO_W +: scr_pkg::PRIO_W] == $past(hwdata[scr_pkg::PRIO_W-1:0]))
    else $error("priority 3 write lost");

  a_prio_read: assert property (rd_req && a == scr_pkg::OFS_PRIO_BASE && acc_ok
    |=> hrdata == 32'($past(prio_cfg[scr_pkg::PRIO_W-1:0])))
    else $error("priority read wrong");

  a_chip0_write: assert property (s_reg.wr_pend && s_reg.wr_addr == scr_pkg::OFS_CHIP_BASE &&
    acc_ok |=> s_reg.chip[scr_pkg::CHIP_W-1:0] == $past(hwdata[scr_pkg::CHIP_W-1:0]))
    else $error("chip 0 write lost");

  a_chip_read: assert property (rd_req && a == scr_pkg::OFS_CHIP_BASE && acc_ok
    |=> hrdata == 32'($past(s_reg.chip[scr_pkg::CHIP_W-1:0])))
    else $error("chip read wrong");

  a_uout_hold: assert property (!(s_reg.wr_pend && s_reg.wr_addr == scr_pkg::OFS_USER_OUT)
    |=> $stable(user_out))
    else $error("user output moved");

  a_probe_write: assert property (s_reg.wr_pend && s_reg.wr_addr == scr_pkg::OFS_CHIP_PROBE
    |=> s_reg.probe == $past(hwdata[7:0]))
    else $error("probe write lost");

  // ----------------------------------------------------------------
  // Chip decode and identification
  // ----------------------------------------------------------------
  a_order_none: assert property (chip_hit == '0 |-> !chip_bank_first)
    else $error("order set with no hit");

  a_hit_mask_zero: assert property (##1 (s_reg.chip[(NUM_CHIPS-1)*scr_pkg::CHIP_W +: 8] == 8'h00
    && $stable(s_reg.chip)) |-> chip_hit[NUM_CHIPS-1])
    else $error("empty mask did not hit");

  a_ident2_read: assert property (rd_req && a == scr_pkg::OFS_IDENT_BASE + 12'h008
    |=> hrdata == {24'h0, scr_pkg::ID_REVISION, scr_pkg::ID_DESIGNER[7:4]})
    else $error("ident2 wrong");

  a_ident3_read: assert property (rd_req && a == scr_pkg::OFS_IDENT_BASE + 12'h00C
    |=> hrdata == {24'h0, scr_pkg::ID_INTEG})
    else $error("ident3 wrong");

  c_bank_first: cover property (chip_bank_first);
  c_cfg_write: cover property (wr_srt && acc_ok);
  c_blocked_write: cover property (wr_srt && !acc_ok);
  c_chip_hit: cover property (chip_hit != '0);
  c_lowpwr: cover property (s_reg.st == scr_pkg::SCR_ST_LOWPWR);
endmodule

// ==== sim/scr_regs_bench.sv ====
// Self-checking bench for the upper configuration register bank.
// Assumes scr_pkg is compiled first; the lone slave's hreadyout is fed back as hready.
`timescale 1ns/1ps
module scr_regs_bench;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, chip_bank_first, open;
  logic [31:0] haddr, hwdata, hrdata, rd, idv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] user_in, user_out, self_refresh_time, probe, srt, v;
  logic [3:0] ctrl_state, chip_hit, h;
  logic [39:0] prio_cfg;
  logic [16:0] chip_mem [4];
  logic [9:0] pv [4];
  logic [3:0] sts [4];
  integer seed = 96749;
  int err_total = 0;
  int n_tests = 0;
  assign hready = hreadyout;
  scr_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .user_in(user_in), .user_out(user_out),
    .ctrl_state(ctrl_state), .prio_cfg(prio_cfg), .self_refresh_time(self_refresh_time),
    .chip_hit(chip_hit), .chip_bank_first(chip_bank_first));
  // ----------------------------------------------------------------
  // Clock, watchdog, checking and bus tasks
  // ----------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  initial begin
    repeat (20000) @(posedge hclk);
    err_total++;
    end_sim();
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("tests=%0d errors=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // One single word transfer; read data lands in rd
  task ahb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {20'h0_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'b010;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
    #1;
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    ahb(a, 1'b0, 32'h0000_0000);
    chk(rd & m, e & m);
  endtask
  function automatic logic [3:0] hitf(input logic [7:0] p);
    for (int i = 0; i < 4; i++) hitf[i] = ((p ^ chip_mem[i][15:8]) & chip_mem[i][7:0]) == 8'h00;
  endfunction
  function automatic logic ordf(input logic [3:0] hh);
    ordf = 1'b0;
    for (int i = 3; i >= 0; i--) if (hh[i]) ordf = chip_mem[i][16];
  endfunction
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    user_in = 8'h00;
    sts = '{scr_pkg::SCR_ST_READY, scr_pkg::SCR_ST_PAUSED, scr_pkg::SCR_ST_LOWPWR,
      scr_pkg::SCR_ST_CONFIG};
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    chk(ctrl_state, 4'b0001);
    chk({hreadyout, hresp}, 2'b10);
    srt = $random(seed);
    ahb(scr_pkg::OFS_SELF_REFRESH, 1'b1, {24'h00_0000, srt});
    rdc(scr_pkg::OFS_SELF_REFRESH, 32'h0000_00FF, srt);
    chk(self_refresh_time, srt);
    for (int i = 0; i < 4; i++) begin
      pv[i] = $random(seed);
      ahb(scr_pkg::OFS_PRIO_BASE + 12'(i * 16), 1'b1, {22'h0, pv[i]});
    end
    for (int i = 0; i < 4; i++) begin
      rdc(scr_pkg::OFS_PRIO_BASE + 12'(i * 16), 32'h0000_03FF, pv[i]);
      chk(prio_cfg[10*i +: 10], pv[i]);
    end
    for (int i = 0; i < 4; i++) begin
      chip_mem[i] = $random(seed);
      if (i == 3) chip_mem[i][7:0] = 8'h00;
      if (i == 0) chip_mem[i][7:0] = 8'hFF;
      ahb(scr_pkg::OFS_CHIP_BASE + 12'(i * 64), 1'b1, {15'h0, chip_mem[i]});
      rdc(scr_pkg::OFS_CHIP_BASE + 12'(i * 64), 32'h0001_FFFF, chip_mem[i]);
    end
    for (int k = 0; k < 12; k++) begin
      probe = (k < 4) ? chip_mem[k][15:8] : 8'($random(seed));
      h = hitf(probe);
      ahb(scr_pkg::OFS_CHIP_PROBE, 1'b1, {24'h0, probe});
      repeat (2) @(posedge hclk);
      #1;
      chk(chip_hit, h);
      chk(chip_bank_first, ordf(h));
      rdc(scr_pkg::OFS_CHIP_HIT, 32'h0000_010F, {23'h0, ordf(h), 4'h0, h});
    end
    idv = {scr_pkg::ID_INTEG, scr_pkg::ID_REVISION, scr_pkg::ID_DESIGNER, scr_pkg::ID_PART};
    for (int i = 0; i < 4; i++) begin
      rdc(scr_pkg::OFS_IDENT_BASE + 12'(i * 4), 32'h0000_00FF, idv >> (8 * i));
    end
    rdc(12'h800, 32'hFFFF_FFFF, 32'h0000_0000);
    for (int s = 0; s < 4; s++) begin
      ahb(scr_pkg::OFS_CTRL_STATE, 1'b1, {28'h0, sts[s]});
      chk(ctrl_state, sts[s]);
      open = sts[s] == scr_pkg::SCR_ST_LOWPWR || sts[s] == scr_pkg::SCR_ST_CONFIG;
      user_in <= 8'($random(seed));
      v = $random(seed);
      ahb(scr_pkg::OFS_USER_OUT, 1'b1, {24'h0, v});
      chk(user_out, v);
      rdc(scr_pkg::OFS_USER_IN, 32'h0000_00FF, user_in);
      v = $random(seed);
      ahb(scr_pkg::OFS_SELF_REFRESH, 1'b1, {24'h0, v});
      if (open) srt = v;
      rdc(scr_pkg::OFS_SELF_REFRESH, 32'h0000_00FF, open ? srt : 8'h00);
      chk(self_refresh_time, srt);
      v = $random(seed);
      ahb(scr_pkg::OFS_PRIO_BASE, 1'b1, {24'h0, v});
      if (open) pv[0] = {2'b00, v};
      chk(prio_cfg[9:0], pv[0]);
    end
    end_sim();
  end
endmodule
